// >>> shared/dhife_pkg.sv
// Shared constants and types for the display host interface front end.
// Assumes both link ends and the link interface compile after this file.
`default_nettype none

package dhife_pkg;

    // ----------------------------------------
    // Bus mode straps, bit 0 is strap pin 0
    // ----------------------------------------
    localparam logic [2:0] MODE_I2C = 3'h2;
    localparam logic [2:0] MODE_6800 = 3'h4;
    localparam logic [2:0] MODE_8080 = 3'h6;
    localparam logic [2:0] MODE_SPI4 = 3'h0;
    localparam logic [2:0] MODE_SPI3 = 3'h1;

    // ----------------------------------------
    // Data bus pin roles in serial modes
    // ----------------------------------------
    localparam int SCK_BIT = 0;
    localparam int SDI_BIT = 1;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;

    // ----------------------------------------
    // Host controller registers
    // ----------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_TX = 3'h1;
    localparam logic [2:0] REG_STAT = 3'h2;
    localparam logic [2:0] REG_RX = 3'h3;
    localparam logic [2:0] REG_CFG = 3'h4;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int CTRL_DC_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int CFG_STRAP_LSB = 0;
    localparam int CFG_INIT_BIT = 3;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] TX_RST = 8'h00;
    localparam logic [7:0] RX_RST = 8'h00;

    // ----------------------------------------
    // Host timing in CLK cycles
    // ----------------------------------------
    localparam logic [3:0] PHASE_CYC = 4'h8;
    localparam logic [3:0] SCK_HALF_CYC = 4'h4;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_STROBE = 3'b010,
        H_HOLD = 3'b011,
        H_SCK_LO = 3'b100,
        H_SCK_HI = 3'b101
    } dhife_hstate_e;

    typedef struct packed {
        logic cs_n;
        logic dc;
        logic e_rd;
        logic rw_wr;
        logic [2:0] straps;
        logic [7:0] d;
    } dhife_pins_s;

    function automatic logic dhife_is_par(input logic [2:0] m);
        return (m == MODE_6800) || (m == MODE_8080);
    endfunction

endpackage

`default_nettype wire

// >>> shared/dhife_link_if.sv
// Pin-level link between host controller and display front end.
// Assumes the bench supplies the link clock; undriven bus bits read low.
`timescale 1ns/1ns
`default_nettype none

interface dhife_link_if (
    input wire logic link_clk
);
    logic chip_init_n;
    logic [2:0] bus_mode_straps;
    logic cs_n;
    logic dc_sel;
    logic e_rd;
    logic rw_wr;
    logic [7:0] d_host_o;
    logic d_host_oe;
    logic [7:0] d_dev_o;
    logic d_dev_oe;
    logic [7:0] d_bus;

    // ----------------------------------------
    // Wire level, unused bits grounded
    // ----------------------------------------
    assign d_bus = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : 8'h00);

    modport host (
        output chip_init_n,
        output bus_mode_straps,
        output cs_n,
        output dc_sel,
        output e_rd,
        output rw_wr,
        output d_host_o,
        output d_host_oe,
        input d_bus
    );

    modport dev (
        input link_clk,
        input chip_init_n,
        input bus_mode_straps,
        input cs_n,
        input dc_sel,
        input e_rd,
        input rw_wr,
        input d_bus,
        output d_dev_o,
        output d_dev_oe
    );
endinterface

`default_nettype wire

// >>> rtl/dhife_dev.sv
// Display-side front end: turns host bus cycles into command and data
// writes, status reads and prefetched display RAM reads.
// Assumes the command decoder answers RAM_RD_REQ one cycle later.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Three straps pick the bus mode
// - Low init pin resets whole chip
// - Strobes and serial clock need chip select
// - D/C high means data, low command
// - Parallel read: D/C low status, high RAM
// - 6800: R/W low write, high read
// - 6800: enable rises, write latched on fall
// - Host issues one dummy RAM read first
// - 8080: read strobe low, device drives bus
// - 8080: read strobe rise ends read
// - 8080: write strobe rise captures byte
// - 4-wire: shift serial line MSB first
// - 4-wire: eighth edge samples D/C, writes
// - Serial modes are write-only
// - Serial clock on bit 0, data bit 1
// - Board ties strobes low in serial modes
// - I2C: D/C pin is address extension
// - Clock select picks internal or external
module dhife_dev (
    dhife_link_if.dev LNK,
    input wire logic EXT_CLOCK_IN,
    input wire logic CLOCK_SOURCE_SEL,
    input wire logic [7:0] STATUS_BYTE,
    input wire logic [7:0] RAM_RD_DATA,
    output logic CMD_WR,
    output logic DATA_WR,
    output logic [7:0] WR_BYTE,
    output logic RAM_RD_REQ,
    output logic [2:0] BUS_MODE,
    output logic SLAVE_ADDR_EXT
);

    // ----------------------------------------
    // Core clock and reset
    // ----------------------------------------
    logic core_clk;
    logic init_s1_r;
    logic init_s2_r;
    logic rst;

    // Strap-level select only; not switched while running
    assign core_clk = CLOCK_SOURCE_SEL ? LNK.link_clk : EXT_CLOCK_IN;

    always_ff @(posedge core_clk) begin
        init_s1_r <= ~LNK.chip_init_n;
        init_s2_r <= init_s1_r;
    end

    assign rst = init_s2_r;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    dhife_pkg::dhife_pins_s pin_now;
    dhife_pkg::dhife_pins_s pin_s1_r;
    dhife_pkg::dhife_pins_s pin_s2_r;
    dhife_pkg::dhife_pins_s pin_old_r;

    always_comb begin
        pin_now.cs_n = LNK.cs_n;
        pin_now.dc = LNK.dc_sel;
        pin_now.e_rd = LNK.e_rd;
        pin_now.rw_wr = LNK.rw_wr;
        pin_now.straps = LNK.bus_mode_straps;
        pin_now.d = LNK.d_bus;
    end

    // Host strobes are asynchronous to the core clock
    always_ff @(posedge core_clk) begin
        pin_s1_r <= pin_now;
        pin_s2_r <= pin_s1_r;
    end

    // Edge reference, reset loads all-zero pin levels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_old_r <= '0;
        end else begin
            pin_old_r <= pin_s2_r;
        end
    end

    // ----------------------------------------
    // Bus mode
    // ----------------------------------------
    logic [2:0] mode_r;
    logic is_6800;
    logic is_8080;
    logic is_spi4;
    logic is_par;

    // Straps caught while reset holds, frozen after release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_r <= pin_s2_r.straps;
        end
    end

    assign is_6800 = mode_r == dhife_pkg::MODE_6800;
    assign is_8080 = mode_r == dhife_pkg::MODE_8080;
    assign is_spi4 = mode_r == dhife_pkg::MODE_SPI4;
    assign is_par = dhife_pkg::dhife_is_par(mode_r);

    // ----------------------------------------
    // Strobe decoding
    // ----------------------------------------
    logic sel;
    logic e_fall;
    logic e_rise;
    logic wr_rise;
    logic sck_rise;
    logic par_wr;
    logic par_rd_end;
    logic par_rd_open;

    assign sel = ~pin_s2_r.cs_n;
    assign e_fall = pin_old_r.e_rd & ~pin_s2_r.e_rd;
    assign e_rise = ~pin_old_r.e_rd & pin_s2_r.e_rd;
    assign wr_rise = ~pin_old_r.rw_wr & pin_s2_r.rw_wr;
    assign sck_rise = ~pin_old_r.d[dhife_pkg::SCK_BIT]
        & pin_s2_r.d[dhife_pkg::SCK_BIT];

    // Serial modes decode no strobe, so tied strobe pins are moot
    always_comb begin
        par_wr = 1'b0;
        par_rd_end = 1'b0;
        par_rd_open = 1'b0;
        if (sel && is_6800) begin
            par_wr = e_fall & ~pin_s2_r.rw_wr;
            par_rd_end = e_fall & pin_s2_r.rw_wr;
            par_rd_open = pin_s2_r.e_rd & pin_s2_r.rw_wr;
        end else if (sel && is_8080) begin
            par_wr = wr_rise & pin_s2_r.e_rd;
            par_rd_end = e_rise & pin_s2_r.rw_wr;
            par_rd_open = ~pin_s2_r.e_rd & pin_s2_r.rw_wr;
        end
    end

    // ----------------------------------------
    // 4-wire serial receiver
    // ----------------------------------------
    logic [7:0] spi_sh_r;
    logic [2:0] spi_cnt_r;
    logic spi_done;
    logic [7:0] spi_byte;

    assign spi_byte = {spi_sh_r[6:0], pin_s2_r.d[dhife_pkg::SDI_BIT]};
    assign spi_done = is_spi4 & sel & sck_rise
        & (spi_cnt_r == dhife_pkg::SPI_LAST_BIT);

    // Deselect drops a partial byte so framing restarts cleanly
    always_ff @(posedge core_clk) begin
        if (rst || !sel || !is_spi4) begin
            spi_cnt_r <= 3'h0;
        end else if (sck_rise) begin
            spi_cnt_r <= spi_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            spi_sh_r <= 8'h00;
        end else if (is_spi4 && sel && sck_rise) begin
            spi_sh_r <= spi_byte;
        end
    end

    // ----------------------------------------
    // Write path to command decoder
    // ----------------------------------------
    logic wr_evt;
    logic [7:0] wr_src;
    logic cmd_wr_r;
    logic data_wr_r;
    logic [7:0] wr_byte_r;

    assign wr_evt = par_wr | spi_done;
    assign wr_src = spi_done ? spi_byte : pin_s2_r.d;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_wr_r <= 1'b0;
            data_wr_r <= 1'b0;
        end else begin
            cmd_wr_r <= wr_evt & ~pin_s2_r.dc;
            data_wr_r <= wr_evt & pin_s2_r.dc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_byte_r <= 8'h00;
        end else if (wr_evt) begin
            wr_byte_r <= wr_src;
        end
    end

    // ----------------------------------------
    // Read path with one-deep prefetch
    // ----------------------------------------
    logic ram_req_r;
    logic ram_take_r;
    logic [7:0] ram_latch_r;
    logic [7:0] d_out_r;
    logic d_oe_r;

    // Each data read returns the byte fetched after the previous
    // one, hence the dummy read the host must issue first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ram_req_r <= 1'b0;
            ram_take_r <= 1'b0;
        end else begin
            ram_req_r <= par_rd_end & pin_s2_r.dc;
            ram_take_r <= ram_req_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ram_latch_r <= 8'h00;
        end else if (ram_take_r) begin
            ram_latch_r <= RAM_RD_DATA;
        end
    end

    // Serial modes never open a read, so no read-back exists
    always_ff @(posedge core_clk) begin
        if (rst) begin
            d_oe_r <= 1'b0;
            d_out_r <= 8'h00;
        end else begin
            d_oe_r <= is_par & par_rd_open;
            d_out_r <= pin_s2_r.dc ? ram_latch_r : STATUS_BYTE;
        end
    end

    // ----------------------------------------
    // I2C address extension
    // ----------------------------------------
    logic sa_ext_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sa_ext_r <= 1'b0;
        end else begin
            sa_ext_r <= (mode_r == dhife_pkg::MODE_I2C) & pin_s2_r.dc;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign LNK.d_dev_o = d_out_r;
    assign LNK.d_dev_oe = d_oe_r;
    assign CMD_WR = cmd_wr_r;
    assign DATA_WR = data_wr_r;
    assign WR_BYTE = wr_byte_r;
    assign RAM_RD_REQ = ram_req_r;
    assign BUS_MODE = mode_r;
    assign SLAVE_ADDR_EXT = sa_ext_r;

endmodule

`default_nettype wire

// >>> rtl/dhife_host.sv
// Host-side controller: software registers drive one bus cycle at a
// time in 6800, 8080 or 4-wire serial form.
// Assumes a plain register port and the link interface on the far side.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module dhife_host (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RD_DATA,
    dhife_link_if.host LNK
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] cfg_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [7:0] rd_data_r;
    logic op_rd_r;
    logic busy;
    logic [2:0] mode;
    logic start;
    logic start_ok;
    dhife_pkg::dhife_hstate_e st_r;

    assign mode = cfg_r[dhife_pkg::CFG_STRAP_LSB +: 3];
    assign busy = st_r != dhife_pkg::H_IDLE;
    assign start = WR_STB && ADDR == dhife_pkg::REG_CTRL
        && WR_DATA[dhife_pkg::CTRL_START_BIT] && !busy;
    // Serial reads and unsupported modes are dropped
    assign start_ok = start && (dhife_pkg::dhife_is_par(mode)
        || (mode == dhife_pkg::MODE_SPI4
        && !WR_DATA[dhife_pkg::CTRL_READ_BIT]));

    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_r <= dhife_pkg::CFG_RST;
        end else if (WR_STB && ADDR == dhife_pkg::REG_CFG) begin
            cfg_r <= WR_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_r <= dhife_pkg::TX_RST;
        end else if (WR_STB && ADDR == dhife_pkg::REG_TX && !busy) begin
            tx_r <= WR_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_data_r <= 8'h00;
        end else if (RD_STB) begin
            case (ADDR)
                dhife_pkg::REG_TX: rd_data_r <= tx_r;
                dhife_pkg::REG_STAT: rd_data_r <= {7'h00, busy};
                dhife_pkg::REG_RX: rd_data_r <= rx_r;
                dhife_pkg::REG_CFG: rd_data_r <= cfg_r;
                default: rd_data_r <= 8'h00;
            endcase
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    // ----------------------------------------
    // Bus input synchroniser
    // ----------------------------------------
    logic [7:0] d_s1_r;
    logic [7:0] d_s2_r;

    always_ff @(posedge CLK) begin
        d_s1_r <= LNK.d_bus;
        d_s2_r <= d_s1_r;
    end

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    logic [3:0] cnt_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic cs_n_r;
    logic dc_r;
    logic e_rd_r;
    logic rw_wr_r;
    logic [7:0] dout_r;
    logic doe_r;
    logic is_8080;
    logic tick;

    assign is_8080 = mode == dhife_pkg::MODE_8080;
    assign tick = cnt_r == 4'h0;

    // Phases are long so the device's two-stage sampling sees each level
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r <= dhife_pkg::H_IDLE;
            cnt_r <= 4'h0;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            op_rd_r <= 1'b0;
            rx_r <= dhife_pkg::RX_RST;
            cs_n_r <= 1'b1;
            dc_r <= 1'b0;
            e_rd_r <= 1'b0;
            rw_wr_r <= 1'b0;
            dout_r <= 8'h00;
            doe_r <= 1'b0;
        end else begin
            if (!tick) begin
                cnt_r <= cnt_r - 4'h1;
            end
            case (st_r)
                dhife_pkg::H_IDLE: begin
                    e_rd_r <= is_8080;
                    rw_wr_r <= is_8080;
                    if (start_ok) begin
                        op_rd_r <= WR_DATA[dhife_pkg::CTRL_READ_BIT];
                        dc_r <= WR_DATA[dhife_pkg::CTRL_DC_BIT];
                        cs_n_r <= 1'b0;
                        if (mode == dhife_pkg::MODE_SPI4) begin
                            sh_r <= tx_r;
                            bit_r <= 3'h0;
                            dout_r <= {6'h00, tx_r[7], 1'b0};
                            doe_r <= 1'b1;
                            cnt_r <= dhife_pkg::SCK_HALF_CYC - 4'h1;
                            st_r <= dhife_pkg::H_SCK_LO;
                        end else begin
                            if (!is_8080) begin
                                rw_wr_r <= WR_DATA[dhife_pkg::CTRL_READ_BIT];
                            end
                            dout_r <= tx_r;
                            doe_r <= ~WR_DATA[dhife_pkg::CTRL_READ_BIT];
                            cnt_r <= dhife_pkg::PHASE_CYC - 4'h1;
                            st_r <= dhife_pkg::H_SETUP;
                        end
                    end
                end
                dhife_pkg::H_SETUP: begin
                    if (tick) begin
                        if (!is_8080) begin
                            e_rd_r <= 1'b1;
                        end else if (op_rd_r) begin
                            e_rd_r <= 1'b0;
                        end else begin
                            rw_wr_r <= 1'b0;
                        end
                        cnt_r <= dhife_pkg::PHASE_CYC - 4'h1;
                        st_r <= dhife_pkg::H_STROBE;
                    end
                end
                dhife_pkg::H_STROBE: begin
                    if (tick) begin
                        if (op_rd_r) begin
                            rx_r <= d_s2_r;
                        end
                        e_rd_r <= is_8080;
                        rw_wr_r <= is_8080 | op_rd_r;
                        cnt_r <= dhife_pkg::PHASE_CYC - 4'h1;
                        st_r <= dhife_pkg::H_HOLD;
                    end
                end
                dhife_pkg::H_HOLD: begin
                    if (tick) begin
                        cs_n_r <= 1'b1;
                        doe_r <= 1'b0;
                        st_r <= dhife_pkg::H_IDLE;
                    end
                end
                dhife_pkg::H_SCK_LO: begin
                    if (tick) begin
                        dout_r[dhife_pkg::SCK_BIT] <= 1'b1;
                        cnt_r <= dhife_pkg::SCK_HALF_CYC - 4'h1;
                        st_r <= dhife_pkg::H_SCK_HI;
                    end
                end
                dhife_pkg::H_SCK_HI: begin
                    if (tick) begin
                        dout_r[dhife_pkg::SCK_BIT] <= 1'b0;
                        cnt_r <= dhife_pkg::SCK_HALF_CYC - 4'h1;
                        if (bit_r == dhife_pkg::SPI_LAST_BIT) begin
                            cnt_r <= dhife_pkg::PHASE_CYC - 4'h1;
                            st_r <= dhife_pkg::H_HOLD;
                        end else begin
                            bit_r <= bit_r + 3'h1;
                            sh_r <= {sh_r[6:0], 1'b0};
                            dout_r[dhife_pkg::SDI_BIT] <= sh_r[6];
                            st_r <= dhife_pkg::H_SCK_LO;
                        end
                    end
                end
                default: begin
                    st_r <= dhife_pkg::H_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign RD_DATA = rd_data_r;
    assign LNK.chip_init_n = cfg_r[dhife_pkg::CFG_INIT_BIT];
    assign LNK.bus_mode_straps = mode;
    assign LNK.cs_n = cs_n_r;
    assign LNK.dc_sel = dc_r;
    assign LNK.e_rd = e_rd_r;
    assign LNK.rw_wr = rw_wr_r;
    assign LNK.d_host_o = dout_r;
    assign LNK.d_host_oe = doe_r;

endmodule

`default_nettype wire

// >>> verification/dhife_link_chk.sv
// Checker of the wires between host controller and front end.
// Assumes instantiation beside the link interface in the bench.
`timescale 1ns/1ns
`default_nettype none

module dhife_link_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic link_clk,
    input wire logic chip_init_n,
    input wire logic [2:0] bus_mode_straps,
    input wire logic cs_n,
    input wire logic e_rd,
    input wire logic rw_wr,
    input wire logic d_host_oe,
    input wire logic d_dev_oe,
    input wire logic [7:0] d_bus
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic m68, m80, spi, off;
    logic [3:0] sck_cnt_r;
    // Bus is unknown until the front end has left reset
    assign off = RST || !chip_init_n;
    assign m68 = bus_mode_straps == dhife_pkg::MODE_6800;
    assign m80 = bus_mode_straps == dhife_pkg::MODE_8080;
    assign spi = bus_mode_straps == dhife_pkg::MODE_SPI4;
    // Partial frames are lost at deselect, so count restarts there
    always_ff @(posedge CLK) begin
        if (RST || cs_n) begin
            sck_cnt_r <= 4'h0;
        end else if ($rose(d_bus[dhife_pkg::SCK_BIT])) begin
            sck_cnt_r <= sck_cnt_r + 4'h1;
        end
    end
    sequence s_e_strobe;
        (e_rd && !cs_n)[*8] ##1 (!e_rd && !cs_n);
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_e_strobe_frame: assert property (@(posedge CLK) disable iff (off)
        m68 && $rose(e_rd) |-> s_e_strobe) else $error("enable frame");
    a_rw_on_write: assert property (@(posedge CLK) disable iff (off)
        m68 && e_rd && d_host_oe |-> !rw_wr) else $error("rw on write");
    a_wr_needs_rd: assert property (@(posedge CLK) disable iff (off)
        m80 && !cs_n && !rw_wr |-> e_rd) else $error("rd during wr");
    a_rd_needs_wr: assert property (@(posedge CLK) disable iff (off)
        m80 && !cs_n && !e_rd |-> rw_wr && !d_host_oe)
        else $error("wr during rd");
    a_serial_tied: assert property (@(posedge CLK) disable iff (off)
        spi && !cs_n |-> !e_rd && !rw_wr) else $error("strobe in serial");
    a_sck_count: assert property (@(posedge CLK) disable iff (off)
        spi && $rose(cs_n) |-> sck_cnt_r == 4'h8) else $error("sck count");
    a_sck_idle_low: assert property (@(posedge CLK) disable iff (off)
        spi && cs_n |-> !d_bus[dhife_pkg::SCK_BIT]) else $error("sck idle");
    a_sdi_held: assert property (@(posedge CLK) disable iff (off)
        spi && $rose(d_bus[dhife_pkg::SCK_BIT])
        |=> $stable(d_bus[dhife_pkg::SDI_BIT])) else $error("sdi moved");
    a_dev_drive: assert property (@(posedge link_clk)
        disable iff (!chip_init_n)
        d_dev_oe |-> !cs_n && !d_host_oe && (m68 || m80))
        else $error("device drive");
endmodule

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench: host controller driving the display front end.
// Assumes both ends, the link interface and the checker compile first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wstb = 1'b0;
    logic rstb = 1'b0;
    logic [7:0] rdata, wr_byte, last_byte;
    logic [7:0] ram = 8'h30;
    logic cmd_wr, data_wr, rd_req, last_dc, sa_ext;
    logic [2:0] bus_mode;
    int wr_cnt = 0;
    int bad_count = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    // Offset start puts a link clock rising edge on a host clock rising edge every 24 ns
    initial begin
        #1;
        forever #3 lclk = ~lclk;
    end
    // ----------------------------------------
    // Ends, link and checker
    // ----------------------------------------
    dhife_link_if lnk (.link_clk(lclk));
    dhife_host dhife_host_i (.CLK(clk), .RST(rst), .ADDR(addr),
        .WR_DATA(wdata), .WR_STB(wstb), .RD_STB(rstb), .RD_DATA(rdata),
        .LNK(lnk.host));
    dhife_dev dhife_dev_i (.LNK(lnk.dev), .EXT_CLOCK_IN(1'b0),
        .CLOCK_SOURCE_SEL(1'b1), .STATUS_BYTE(8'h5a), .RAM_RD_DATA(ram),
        .CMD_WR(cmd_wr), .DATA_WR(data_wr), .WR_BYTE(wr_byte),
        .RAM_RD_REQ(rd_req), .BUS_MODE(bus_mode), .SLAVE_ADDR_EXT(sa_ext));
    dhife_link_chk dhife_link_chk_i (.CLK(clk), .RST(rst), .link_clk(lclk),
        .chip_init_n(lnk.chip_init_n), .bus_mode_straps(lnk.bus_mode_straps),
        .cs_n(lnk.cs_n), .e_rd(lnk.e_rd), .rw_wr(lnk.rw_wr),
        .d_host_oe(lnk.d_host_oe), .d_dev_oe(lnk.d_dev_oe), .d_bus(lnk.d_bus));
    // ----------------------------------------
    // Display RAM and write monitor
    // ----------------------------------------
    always @(posedge lclk) begin
        if (rd_req === 1'b1) begin
            ram <= ram + 8'h11;
        end
        if (cmd_wr === 1'b1 || data_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_dc <= data_wr;
            last_byte <= wr_byte;
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic go(input logic [7:0] c);
        logic [7:0] v;
        wr(dhife_pkg::REG_CTRL, c);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 100; i++) begin
            rd(dhife_pkg::REG_STAT, v);
            if (v[0] !== 1'b1) break;
        end
        chk(v & 8'h01, 8'h00);
    endtask
    task automatic set_mode(input logic [2:0] m);
        wr(dhife_pkg::REG_CFG, {5'h00, m});
        repeat (10) @(posedge clk);
        chk(wr_byte, 8'h00);
        wr(dhife_pkg::REG_CFG, {5'h01, m});
        repeat (10) @(posedge clk);
        chk({5'h00, bus_mode}, {5'h00, m});
    endtask
    task automatic send(input logic dc, input logic [7:0] b);
        int n;
        n = wr_cnt;
        wr(dhife_pkg::REG_TX, b);
        go({5'h00, dc, 2'b01});
        chk(8'(wr_cnt - n), 8'h01);
        chk({7'h00, last_dc}, {7'h00, dc});
        chk(last_byte, b);
    endtask
    task automatic fetch(input logic dc, input logic [7:0] e);
        logic [7:0] v;
        go({5'h00, dc, 2'b11});
        rd(dhife_pkg::REG_RX, v);
        chk(v, e);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        logic [7:0] v;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(dhife_pkg::REG_CFG, v);
        chk(v, dhife_pkg::CFG_RST);
        rd(3'h7, v);
        chk(v, 8'h00);
        for (int i = 0; i < 2; i++) begin
            set_mode(i ? dhife_pkg::MODE_8080 : dhife_pkg::MODE_6800);
            send(1'b0, 8'ha5);
            send(1'b1, 8'h3c);
            fetch(1'b0, 8'h5a);
            go(8'h07);
            fetch(1'b1, ram);
        end
        set_mode(dhife_pkg::MODE_SPI4);
        send(1'b0, 8'h96);
        send(1'b1, 8'h81);
        v = ram;
        go(8'h07);
        chk(ram, v);
        set_mode(dhife_pkg::MODE_I2C);
        chk({7'h00, sa_ext}, 8'h01);
        set_mode(dhife_pkg::MODE_SPI3);
        chk({7'h00, sa_ext}, 8'h00);
        end_sim();
    end
endmodule

`default_nettype wire
